// ==== core/gps_pkg.sv ====
// package: constants and types for the general pin settings block
package gps_pkg;
  localparam int         GPS_NPINS       = 4;
  // apb register byte addresses
  localparam logic [7:0] GPS_ADDR_PIN0   = 8'h00;
  localparam logic [7:0] GPS_ADDR_PIN1   = 8'h04;
  localparam logic [7:0] GPS_ADDR_PIN2   = 8'h08;
  localparam logic [7:0] GPS_ADDR_PIN3   = 8'h0c;
  localparam logic [7:0] GPS_ADDR_CLKDIV = 8'h10;
  localparam logic [7:0] GPS_ADDR_EDGE   = 8'h14;
  localparam logic [7:0] GPS_ADDR_CMD    = 8'h18;
  localparam logic [7:0] GPS_ADDR_STATUS = 8'h1c;
  localparam logic [7:0] GPS_ADDR_PININ  = 8'h20;
  // settings byte fields
  localparam int         GPS_SEL_LSB     = 0;
  localparam int         GPS_DIR_BIT     = 3;
  localparam int         GPS_OUT_BIT     = 4;
  localparam logic [7:0] GPS_PIN_RST     = 8'h08;
  // edge register fields
  localparam int         GPS_POS_BIT     = 5;
  localparam int         GPS_NEG_BIT     = 6;
  localparam logic [7:0] GPS_EDGE_RST    = 8'h00;
  localparam logic [4:0] GPS_CLKDIV_RST  = 5'h00;
  // reset command bytes
  localparam logic [7:0] GPS_CMD_RESET   = 8'h70;
  localparam logic [7:0] GPS_KEY1        = 8'hab;
  localparam logic [7:0] GPS_KEY2        = 8'hcd;
  localparam logic [7:0] GPS_KEY3        = 8'hef;
  // function select codes
  localparam logic [2:0] GPS_F_GPIO      = 3'h0;
  localparam logic [2:0] GPS_F_DED       = 3'h1;
  localparam logic [2:0] GPS_F_ALT0      = 3'h2;
  localparam logic [2:0] GPS_F_ALT1      = 3'h3;
  localparam logic [2:0] GPS_F_ALT2      = 3'h4;
  // internal clock figures
  localparam int         GPS_CLK_MHZ     = 40;
  localparam int         GPS_RST_HOLD_NS = 100;
  localparam int         GPS_RST_CYC     =
    (GPS_RST_HOLD_NS * GPS_CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    GPS_PF_GPIO, GPS_PF_DED, GPS_PF_ALT0, GPS_PF_ALT1, GPS_PF_ALT2,
    GPS_PF_NONE
  } gps_func_t;

  typedef struct packed {
    logic [2:0] sel;
    logic       dir_in;
    logic       out_val;
  } gps_pin_cfg_t;

  typedef struct packed {
    logic [31:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } gps_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } gps_apb_rsp_t;

  // decode a pin's select field into a function, per pin number
  function automatic gps_func_t gps_decode(input int pin,
                                           input logic [2:0] sel);
    gps_func_t f;
    f = GPS_PF_NONE;
    if (sel == GPS_F_GPIO) f = GPS_PF_GPIO;
    else if (sel == GPS_F_DED) f = GPS_PF_DED;
    else if (sel == GPS_F_ALT0) f = GPS_PF_ALT0;
    else if (sel == GPS_F_ALT1 && pin != 0) f = GPS_PF_ALT1;
    else if (sel == GPS_F_ALT2 && pin == 1) f = GPS_PF_ALT2;
    return f;
  endfunction
endpackage

// ==== core/gps_clkout.sv ====
// clock output divider with duty select
`timescale 1ns/10ps
module gps_clkout
  import gps_pkg::*;
(
  input  wire logic       i_sys_clk, // system clock
  input  wire logic       i_rst,     // sync reset, active high
  input  wire logic       i_en,      // pin uses clock output
  input  wire logic [4:0] i_setting, // duty [4:3], divider [2:0]
  output logic            o_clk      // divided clock, registered
);
  logic [8:0] cnt_q;
  logic [8:0] period;
  logic [8:0] high_len;

  // divider power of two: 2^(div+1) cycles, up to 256, hence nine bits
  always_comb begin
    period = 9'h002 << i_setting[2:0];
    unique case (i_setting[4:3])
      2'h0: high_len = period >> 1;
      2'h1: high_len = period >> 2;
      2'h2: high_len = period - (period >> 2);
      2'h3: high_len = (period >> 3) | 9'h001;
    endcase
  end

  // counter runs only while enabled, so output is quiet otherwise
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !i_en) begin
      cnt_q <= 9'h000;
      o_clk <= 1'b0;
    end else begin
      cnt_q <= (cnt_q + 9'h001 >= period) ? 9'h000 : cnt_q + 9'h001;
      o_clk <= (cnt_q < high_len);
    end
  end

  property p_clk_idle;
    @(posedge i_sys_clk) disable iff (i_rst) !$past(i_en) |-> !o_clk;
  endproperty
  a_clk_idle: assert property (p_clk_idle)
    else $error("clock out active while off");
endmodule

// ==== core/gps_edge.sv ====
// edge detector with sticky flag
`timescale 1ns/10ps
module gps_edge
  import gps_pkg::*;
(
  input  wire logic i_sys_clk, // system clock
  input  wire logic i_rst,     // sync reset, active high
  input  wire logic i_en,      // pin in edge detect mode
  input  wire logic i_pin,     // pin level
  input  wire logic i_pos_en,  // rising edge enable
  input  wire logic i_neg_en,  // falling edge enable
  input  wire logic i_clr,     // software clear pulse
  output logic      o_flag     // sticky flag, registered
);
  logic prev_q;
  logic hit;

  // edge qualified by enables; set beats clear
  assign hit = i_en && ((i_pos_en && i_pin && !prev_q) ||
                        (i_neg_en && !i_pin && prev_q));

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      prev_q <= 1'b0;
      o_flag <= 1'b0;
    end else begin
      prev_q <= i_pin;
      if (hit) o_flag <= 1'b1;
      else if (i_clr) o_flag <= 1'b0;
    end
  end

  property p_edge_set;
    @(posedge i_sys_clk) disable iff (i_rst) hit |=> o_flag;
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge lost");
endmodule

// ==== core/gps_top.sv ====
// top: apb registers, pin function mux, reset command
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
module gps_top
  import gps_pkg::*;
#(
  parameter int NPINS = 4 // number of general pins
)(
  input  wire logic         i_sys_clk,  // 40 mhz system clock
  input  wire logic         i_rst,      // sync reset, active high
  input  wire gps_pkg::gps_apb_req_t i_apb, // apb request
  output gps_pkg::gps_apb_rsp_t      o_apb, // apb response
  input  wire logic [3:0]   i_pin,      // pin input levels
  output logic [3:0]        o_pin,      // pin output levels
  output logic [3:0]        o_pin_oe,   // pin output enables
  output logic [3:0]        o_ana_en,   // pin given to analog block
  input  wire logic         i_suspend,  // suspend state
  input  wire logic         i_usb_cfg,  // usb configured state
  input  wire logic         i_rx_led,   // rx activity led level
  input  wire logic         i_tx_led,   // tx activity led level
  input  wire logic         i_i2c_led,  // i2c activity led level
  input  wire logic         i_analog_output_one, // analog out one level
  input  wire logic         i_analog_output_two, // analog out two level
  output logic              o_chip_rst, // chip reset pulse, four cycles long
  output logic              o_rsp_req   // response required pulse
);
  import gps_pkg::*;

  // elaboration check: the map and the mux are written for four pins
  if (NPINS != GPS_NPINS) begin : g_npins_check
    $error("gps_top serves exactly four pins");
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  pin_q [4];
  logic [4:0]  clkdiv_q;
  logic [7:0]  edge_q;
  logic [4:0]  rst_cnt_q;
  logic        edge_flag;
  logic        wr_en;
  logic        rd_setup;
  logic [31:0] prdata_q;
  logic        addr_ok;
  logic [31:0] rdata_d;
  logic        key_ok;
  logic        clr_flag;
  gps_func_t   func [4];
  logic        clk_out;

  assign wr_en = i_apb.psel && i_apb.penable && i_apb.pwrite;
  assign rd_setup = i_apb.psel && !i_apb.penable && !i_apb.pwrite;

  // decode address; unmapped gives slave error
  always_comb begin
    addr_ok = 1'b1;
    rdata_d = 32'h0;
    unique case (i_apb.paddr[7:0])
      GPS_ADDR_PIN0:   rdata_d = {24'h0, pin_q[0]};
      GPS_ADDR_PIN1:   rdata_d = {24'h0, pin_q[1]};
      GPS_ADDR_PIN2:   rdata_d = {24'h0, pin_q[2]};
      GPS_ADDR_PIN3:   rdata_d = {24'h0, pin_q[3]};
      GPS_ADDR_CLKDIV: rdata_d = {27'h0, clkdiv_q};
      GPS_ADDR_EDGE:   rdata_d = {24'h0, edge_q};
      GPS_ADDR_CMD:    rdata_d = 32'h0;
      GPS_ADDR_STATUS: rdata_d = {31'h0, edge_flag};
      GPS_ADDR_PININ:  rdata_d = {28'h0, i_pin};
      default:         addr_ok = 1'b0;
    endcase
    if (i_apb.paddr[31:8] != 24'h0) addr_ok = 1'b0;
  end

  // zero wait-state slave
  assign o_apb.pready = 1'b1;
  assign o_apb.pslverr = i_apb.psel && i_apb.penable && !addr_ok;
  assign o_apb.prdata = prdata_q;

  // read data is registered at the setup edge and stands through access
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) prdata_q <= 32'h0;
    else if (rd_setup) prdata_q <= rdata_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // settings bytes: don't-care bits are stored but unused
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      for (int i = 0; i < 4; i++) pin_q[i] <= GPS_PIN_RST;
      clkdiv_q <= GPS_CLKDIV_RST;
      edge_q <= GPS_EDGE_RST;
    end else if (wr_en && addr_ok) begin
      unique case (i_apb.paddr[7:0])
        GPS_ADDR_PIN0:   pin_q[0] <= i_apb.pwdata[7:0];
        GPS_ADDR_PIN1:   pin_q[1] <= i_apb.pwdata[7:0];
        GPS_ADDR_PIN2:   pin_q[2] <= i_apb.pwdata[7:0];
        GPS_ADDR_PIN3:   pin_q[3] <= i_apb.pwdata[7:0];
        GPS_ADDR_CLKDIV: clkdiv_q <= i_apb.pwdata[4:0];
        GPS_ADDR_EDGE:   edge_q <= i_apb.pwdata[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset command: reset code in byte 0, key words in bytes 1..3 of the command word
  assign key_ok = i_apb.pwdata == {GPS_KEY3, GPS_KEY2, GPS_KEY1,
                                   GPS_CMD_RESET};
  assign clr_flag = wr_en && i_apb.paddr[7:0] == GPS_ADDR_STATUS
                    && i_apb.pwdata[0];

  // hold reset out a few cycles so the whole chip sees it
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) rst_cnt_q <= 5'h0;
    else if (wr_en && i_apb.paddr[7:0] == GPS_ADDR_CMD && key_ok)
      rst_cnt_q <= 5'(GPS_RST_CYC);
    else if (rst_cnt_q != 5'h0) rst_cnt_q <= rst_cnt_q - 5'h1;
  end
  assign o_chip_rst = rst_cnt_q != 5'h0;

  // every command except the keyed reset wants a response
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) o_rsp_req <= 1'b0;
    else o_rsp_req <= wr_en && i_apb.paddr[7:0] == GPS_ADDR_CMD
                      && !key_ok;
  end

  ////////////////////////////////////////////////////////////////////////
  // per-pin function decode and output mux
  generate
    for (genvar g = 0; g < 4; g++) begin : g_pin
      assign func[g] = gps_decode(g,
                                  pin_q[g][2:0]);
    end
  endgenerate

  always_comb begin
    o_pin = 4'h0;
    o_pin_oe = 4'h0;
    o_ana_en = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (func[i] == GPS_PF_GPIO) begin
        o_pin_oe[i] = !pin_q[i][GPS_DIR_BIT];
        o_pin[i] = pin_q[i][GPS_OUT_BIT];
      end
    end
    // pin zero: suspend, rx led
    if (func[0] == GPS_PF_DED) begin
      o_pin_oe[0] = 1'b1;
      o_pin[0] = i_suspend;
    end else if (func[0] == GPS_PF_ALT0) begin
      o_pin_oe[0] = 1'b1;
      o_pin[0] = i_rx_led;
    end
    // pin one: clock, analog in, tx led, edge detect input
    if (func[1] == GPS_PF_DED) begin
      o_pin_oe[1] = 1'b1;
      o_pin[1] = clk_out;
    end else if (func[1] == GPS_PF_ALT0) o_ana_en[1] = 1'b1;
    else if (func[1] == GPS_PF_ALT1) begin
      o_pin_oe[1] = 1'b1;
      o_pin[1] = i_tx_led;
    end
    // pin two: usb cfg, analog in two, analog out one
    if (func[2] == GPS_PF_DED) begin
      o_pin_oe[2] = 1'b1;
      o_pin[2] = i_usb_cfg;
    end else if (func[2] == GPS_PF_ALT0) o_ana_en[2] = 1'b1;
    else if (func[2] == GPS_PF_ALT1) begin
      o_ana_en[2] = 1'b1;
      o_pin_oe[2] = 1'b1;
      o_pin[2] = i_analog_output_one;
    end
    // pin three: i2c led, analog in three, analog out two
    if (func[3] == GPS_PF_DED) begin
      o_pin_oe[3] = 1'b1;
      o_pin[3] = i_i2c_led;
    end else if (func[3] == GPS_PF_ALT0) o_ana_en[3] = 1'b1;
    else if (func[3] == GPS_PF_ALT1) begin
      o_ana_en[3] = 1'b1;
      o_pin_oe[3] = 1'b1;
      o_pin[3] = i_analog_output_two;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // submodules
  gps_clkout u_clk (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_en      (func[1] == GPS_PF_DED),
    .i_setting (clkdiv_q),
    .o_clk     (clk_out)
  );

  gps_edge u_edge (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_en      (func[1] == GPS_PF_ALT2),
    .i_pin     (i_pin[1]),
    .i_pos_en  (edge_q[GPS_POS_BIT]),
    .i_neg_en  (edge_q[GPS_NEG_BIT]),
    .i_clr     (clr_flag),
    .o_flag    (edge_flag)
  );

  ////////////////////////////////////////////////////////////////////////
  // assertions
  property p_gpio_out;
    @(posedge i_sys_clk) disable iff (i_rst)
      (func[0] == GPS_PF_GPIO && !pin_q[0][GPS_DIR_BIT])
        |-> o_pin_oe[0] && o_pin[0] == pin_q[0][GPS_OUT_BIT];
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("gpio out");

  property p_gpio_in;
    @(posedge i_sys_clk) disable iff (i_rst)
      (func[3] == GPS_PF_GPIO && pin_q[3][GPS_DIR_BIT]) |-> !o_pin_oe[3];
  endproperty
  a_gpio_in: assert property (p_gpio_in) else $error("gpio in");

  property p_ign0;
    @(posedge i_sys_clk) disable iff (i_rst)
      pin_q[0][2:0] > 3'h2 |-> !o_pin_oe[0];
  endproperty
  a_ign0: assert property (p_ign0) else $error("pin0 code");

  property p_ign1;
    @(posedge i_sys_clk) disable iff (i_rst)
      pin_q[1][2:0] > 3'h4 |-> !o_pin_oe[1] && !o_ana_en[1];
  endproperty
  a_ign1: assert property (p_ign1) else $error("pin1 code");

  property p_ign2;
    @(posedge i_sys_clk) disable iff (i_rst)
      pin_q[2][2:0] > 3'h3 |-> !o_pin_oe[2] && !o_ana_en[2];
  endproperty
  a_ign2: assert property (p_ign2) else $error("pin2 code");

  property p_ana_out_two;
    @(posedge i_sys_clk) disable iff (i_rst)
      func[3] == GPS_PF_ALT1
        |-> o_ana_en[3] && o_pin[3] == i_analog_output_two;
  endproperty
  a_ana_out_two: assert property (p_ana_out_two)
    else $error("pin3 analog out");

  property p_rst_cmd;
    @(posedge i_sys_clk) disable iff (i_rst)
      (wr_en && i_apb.paddr[7:0] == GPS_ADDR_CMD && key_ok)
        |=> o_chip_rst [*4] ##1 !o_chip_rst;
  endproperty
  a_rst_cmd: assert property (p_rst_cmd) else $error("chip reset");

  property p_no_rsp;
    @(posedge i_sys_clk) disable iff (i_rst)
      (wr_en && i_apb.paddr[7:0] == GPS_ADDR_CMD)
        |=> o_rsp_req == !$past(key_ok);
  endproperty
  a_no_rsp: assert property (p_no_rsp) else $error("response");

  property p_ign3;
    @(posedge i_sys_clk) disable iff (i_rst)
      pin_q[3][2:0] > 3'h3 |-> !o_pin_oe[3] && !o_ana_en[3];
  endproperty
  a_ign3: assert property (p_ign3) else $error("pin3 code");

  // routed sources must reach the pin unchanged
  property p_suspend_route;
    @(posedge i_sys_clk) disable iff (i_rst)
      func[0] == GPS_PF_DED |-> o_pin_oe[0] && o_pin[0] == i_suspend;
  endproperty
  a_suspend_route: assert property (p_suspend_route)
    else $error("pin0 suspend");

  property p_rx_route;
    @(posedge i_sys_clk) disable iff (i_rst)
      func[0] == GPS_PF_ALT0 |-> o_pin_oe[0] && o_pin[0] == i_rx_led;
  endproperty
  a_rx_route: assert property (p_rx_route)
    else $error("pin0 rx led");

  property p_clk_route;
    @(posedge i_sys_clk) disable iff (i_rst)
      func[1] == GPS_PF_DED |-> o_pin_oe[1] && o_pin[1] == clk_out;
  endproperty
  a_clk_route: assert property (p_clk_route)
    else $error("pin1 clock out");

  // edge detect listens only; driving would mask the edge it watches
  property p_edge_input;
    @(posedge i_sys_clk) disable iff (i_rst)
      func[1] == GPS_PF_ALT2 |-> !o_pin_oe[1] && !o_ana_en[1];
  endproperty
  a_edge_input: assert property (p_edge_input)
    else $error("pin1 edge mode drives");

  property p_usb_cfg_route;
    @(posedge i_sys_clk) disable iff (i_rst)
      func[2] == GPS_PF_DED |-> o_pin_oe[2] && o_pin[2] == i_usb_cfg;
  endproperty
  a_usb_cfg_route: assert property (p_usb_cfg_route)
    else $error("pin2 usb configured");

  property p_ana_out_one;
    @(posedge i_sys_clk) disable iff (i_rst)
      func[2] == GPS_PF_ALT1
        |-> o_ana_en[2] && o_pin[2] == i_analog_output_one;
  endproperty
  a_ana_out_one: assert property (p_ana_out_one)
    else $error("pin2 analog out");

  property p_i2c_route;
    @(posedge i_sys_clk) disable iff (i_rst)
      func[3] == GPS_PF_DED |-> o_pin_oe[3] && o_pin[3] == i_i2c_led;
  endproperty
  a_i2c_route: assert property (p_i2c_route)
    else $error("pin3 i2c led");

  c_reset: cover property (@(posedge i_sys_clk) o_chip_rst);
  c_ana:   cover property (@(posedge i_sys_clk) o_ana_en != 4'h0);
  c_edge:  cover property (@(posedge i_sys_clk) edge_flag);
  c_clk:   cover property (@(posedge i_sys_clk) clk_out);
endmodule

// ==== verification/gps_host_model.sv ====
// host side model: issues register transfers for the command reports
`timescale 1ns/10ps
module gps_host_model
  import gps_pkg::*;
(
  input  wire logic                  i_sys_clk, // system clock
  input  wire gps_pkg::gps_apb_rsp_t i_rsp,     // slave response
  output gps_pkg::gps_apb_req_t      o_req      // master request
);
  import gps_pkg::*;

  initial o_req = '0;

  ////////////////////////////////////////////////////////////////////////
  // one transfer; reserved upper bytes always sent as zero
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e, output logic to);
    to = 1'b1;
    r = '0;
    e = 1'b0;
    @(posedge i_sys_clk);
    o_req <= '{paddr: {24'h0, a}, psel: 1'b1, penable: 1'b0,
               pwrite: w, pwdata: d};
    @(posedge i_sys_clk);
    o_req.penable <= 1'b1;
    // answer taken at the edge that sees pready, before its updates land
    for (int i = 0; i < 20 && to; i++) begin
      @(posedge i_sys_clk);
      if (i_rsp.pready === 1'b1) begin
        r = i_rsp.prdata;
        e = i_rsp.pslverr;
        to = 1'b0;
      end
    end
    // released data lines must not keep the old value
    o_req.psel <= 1'b0;
    o_req.penable <= 1'b0;
    o_req.pwdata <= ~d;
  endtask
endmodule

// ==== verification/tb_top.sv ====
// testbench: pin settings, edge flag, clock out and reset command
`timescale 1ns/10ps
module tb_top;
  import gps_pkg::*;

  logic         clk;
  logic         rst;
  gps_apb_req_t req;
  gps_apb_rsp_t rsp;
  logic [3:0]   pin_in;
  logic [3:0]   o_pin;
  logic [3:0]   oe;
  logic [3:0]   ana;
  logic [6:0]   src; // suspend, usb cfg, rx, tx, i2c, analog out one, two
  logic         crst;
  logic         rsp_req;
  int           n_errors = 0;
  int           tests_run = 0;
  int           n_crst = 0;
  int           n_rsp = 0;
  logic [31:0]  r;
  logic         e;
  int tp[7] = '{0, 0, 1, 2, 2, 3, 3};
  int tc[7] = '{1, 2, 3, 1, 3, 1, 3};
  int ts[7] = '{0, 2, 3, 1, 5, 4, 6};
  int fi[4] = '{3, 5, 4, 4};
  int cs[4] = '{1, 9, 17, 25};
  int ch[4] = '{8, 4, 12, 4};
  logic [31:0] bad[3] = '{32'hefcdab71, 32'hefcdac70, 32'h0};
  int b;
  int h;

  always #12.5 clk = ~clk;

  gps_host_model hst (.i_sys_clk(clk), .i_rsp(rsp), .o_req(req));

  gps_top #(.NPINS(4)) dut (
    .i_sys_clk(clk), .i_rst(rst), .i_apb(req), .o_apb(rsp),
    .i_pin(pin_in), .o_pin(o_pin), .o_pin_oe(oe), .o_ana_en(ana),
    .i_suspend(src[0]), .i_usb_cfg(src[1]), .i_rx_led(src[2]),
    .i_tx_led(src[3]), .i_i2c_led(src[4]), .i_analog_output_one(src[5]),
    .i_analog_output_two(src[6]), .o_chip_rst(crst), .o_rsp_req(rsp_req));

  // count reset-pulse cycles and response pulses
  always @(posedge clk) begin
    if (crst === 1'b1) n_crst++;
    if (rsp_req === 1'b1) n_rsp++;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a hung handshake ends the run
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    logic to;
    hst.xfer(w, a, d, r, e, to);
    if (to) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    acc(1'b0, a, 32'h0);
    chk(r, x);
  endtask

  function automatic logic [7:0] ad(input int p);
    return GPS_ADDR_PIN0 + 8'(4 * p);
  endfunction

  // pin level only matters while driven
  task automatic pc(input int p, input logic eo, input logic ep);
    @(negedge clk);
    chk({30'h0, oe[p], oe[p] & o_pin[p]}, {30'h0, eo, eo & ep});
  endtask

  task automatic ac(input int p, input logic ea);
    @(negedge clk);
    chk({30'h0, ana[p], oe[p]}, {30'h0, ea, 1'b0});
  endtask

  task automatic edge_to(input logic v);
    @(posedge clk);
    pin_in[1] <= v;
    repeat (3) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    pin_in = '0;
    src = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // reset values, then gpio output levels and direction
    for (int p = 0; p < 4; p++) begin
      rd(ad(p), 32'h08);
      pc(p, 1'b0, 1'b0);
      wr(ad(p), 32'h10);
      pc(p, 1'b1, 1'b1);
      wr(ad(p), 32'h00);
      pc(p, 1'b1, 1'b0);
      wr(ad(p), 32'h18);
      pc(p, 1'b0, 1'b0);
    end
    // routed functions; direction bit set but must be ignored
    for (int k = 0; k < 7; k++) begin
      wr(ad(tp[k]), 32'(tc[k]) | 32'h08);
      for (int v = 1; v >= 0; v--) begin
        @(posedge clk);
        src[ts[k]] <= v[0];
        pc(tp[k], 1'b1, v[0]);
      end
    end
    for (int p = 1; p < 4; p++) begin
      wr(ad(p), 32'h02);
      ac(p, 1'b1);
    end
    // ignored codes drive nothing; don't-care bits read back
    for (int p = 0; p < 4; p++) begin
      for (int c = fi[p]; c < 8; c++) begin
        wr(ad(p), 32'he0 | 32'(c));
        ac(p, 1'b0);
        rd(ad(p), 32'he0 | 32'(c));
      end
    end
    // edge detection on pin one
    wr(ad(1), 32'h04);
    wr(GPS_ADDR_EDGE, 32'h20);
    edge_to(1'b1);
    rd(GPS_ADDR_STATUS, 32'h1);
    wr(GPS_ADDR_STATUS, 32'h1);
    rd(GPS_ADDR_STATUS, 32'h0);
    edge_to(1'b0);
    rd(GPS_ADDR_STATUS, 32'h0);
    wr(GPS_ADDR_EDGE, 32'h40);
    edge_to(1'b1);
    rd(GPS_ADDR_STATUS, 32'h0);
    edge_to(1'b0);
    rd(GPS_ADDR_STATUS, 32'h1);
    // clock output: high cycles over whole periods
    wr(ad(1), 32'h01);
    for (int k = 0; k < 4; k++) begin
      wr(GPS_ADDR_CLKDIV, 32'(cs[k]));
      repeat (4) @(posedge clk);
      h = 0;
      repeat (16) begin
        @(negedge clk);
        h += int'(o_pin[1] & oe[1]);
      end
      chk(32'(h), 32'(ch[k]));
    end
    // wrong keys answer once; correct key resets without answer
    for (int k = 0; k < 3; k++) begin
      b = n_rsp;
      wr(GPS_ADDR_CMD, bad[k]);
      repeat (4) @(posedge clk);
      chk(32'(n_rsp - b), 32'h1);
    end
    b = n_rsp;
    wr(GPS_ADDR_CMD, 32'hefcdab70);
    repeat (10) @(posedge clk);
    chk(32'(n_crst), 32'(GPS_RST_CYC));
    chk(32'(n_rsp - b), 32'h0);
    // host resets and reads the settings afresh
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(ad(0), 32'h08);
    // pin levels read back as seen while pins are inputs
    @(posedge clk);
    pin_in <= 4'h5;
    rd(GPS_ADDR_PININ, 32'h5);
    // unmapped place refused
    acc(1'b1, 8'h24, 32'h5);
    chk({31'h0, e}, 32'h1);
    acc(1'b0, 8'h24, 32'h0);
    chk({31'h0, e}, 32'h1);
    tally_and_finish();
  end
endmodule
